// *** logic/hcpio_regs.vh ***
`ifndef HCPIO_REGS_VH
`define HCPIO_REGS_VH

// Controller register byte offsets (Wishbone side)
`define HCPIO_ADR_CTRL 8'h00
`define HCPIO_ADR_WDATA 8'h04
`define HCPIO_ADR_RDATA 8'h08
`define HCPIO_ADR_STATUS 8'h0C
`define HCPIO_ADR_BCOUNT 8'h10
`define HCPIO_ADR_BUFPTR 8'h14
`define HCPIO_ADR_BUFDATA 8'h18
`define HCPIO_ADR_CFG 8'h1C

// Control word fields
`define HCPIO_CTRL_IDX_LSB 0
`define HCPIO_CTRL_IDX_MSB 7
`define HCPIO_CTRL_OP_LSB 8
`define HCPIO_CTRL_OP_MSB 10
`define HCPIO_CTRL_ABORT 30
`define HCPIO_CTRL_GO 31

// Operation codes
`define HCPIO_OP_RD16 3'h0
`define HCPIO_OP_WR16 3'h1
`define HCPIO_OP_RD32 3'h2
`define HCPIO_OP_WR32 3'h3
`define HCPIO_OP_BUFRD 3'h4
`define HCPIO_OP_BUFWR 3'h5
`define HCPIO_OP_DMARD 3'h6
`define HCPIO_OP_DMAWR 3'h7

// Status bits
`define HCPIO_ST_BUSY 0
`define HCPIO_ST_DONE 1
`define HCPIO_ST_IRQ_LEVEL 2
`define HCPIO_ST_IRQ_EDGE 3
`define HCPIO_ST_TRANSFER_REQUEST_OUT 4
`define HCPIO_ST_WORDS_LSB 16

// Configuration bits
`define HCPIO_CFG_IRQ_POL 0
`define HCPIO_CFG_IRQ_EDGE 1
`define HCPIO_CFG_TRANSFER_REQUEST_OUT_HI 2
`define HCPIO_CFG_DACK_LO 3
`define HCPIO_CFG_EOT_EN 4
`define HCPIO_CFG_EOT_HI 5
`define HCPIO_CFG_RESET 6'h1C

// Device pin-level encodings
`define HCPIO_PORT_DATA 1'b0
`define HCPIO_PORT_CMD 1'b1
`define HCPIO_CMD_UPPER 8'h00

// Device register map (command indexes)
`define HCPIO_IDX_HW_SETUP_RD 8'h20
`define HCPIO_IDX_HW_SETUP_WR 8'hA0
`define HCPIO_IDX_DMA_SETUP_RD 8'h21
`define HCPIO_IDX_DMA_SETUP_WR 8'hA1
`define HCPIO_IDX_BYTE_COUNT_RD 8'h22
`define HCPIO_IDX_BYTE_COUNT_WR 8'hA2
`define HCPIO_IDX_CHIP_ID 8'h27
`define HCPIO_DMA_COUNTER_SEL_BIT 2

// Pin timing
`define HCPIO_CLK_NS 20
`define HCPIO_STROBE_NS 40
`define HCPIO_RECOVER_NS 60
`define HCPIO_STROBE_CYC ((`HCPIO_STROBE_NS + `HCPIO_CLK_NS - 1) / `HCPIO_CLK_NS)
`define HCPIO_RECOVER_CYC ((`HCPIO_RECOVER_NS + `HCPIO_CLK_NS - 1) / `HCPIO_CLK_NS)

`endif

// *** logic/hcpio_cycle.v ***
`timescale 1ns/1ps
`default_nettype none
`include "hcpio_regs.vh"

module hcpio_cycle
(
   input wire clk_i,
   input wire rst_i,
   input wire start_i,
   input wire a0_i,
   input wire wr_i,
   input wire dma_i,
   input wire dack_low_i,
   input wire [15:0] wdata_i,
   output reg done_o,
   output reg [15:0] rdata_o,
   output reg cs_n_o,
   output reg a0_o,
   output reg rd_n_o,
   output reg wr_n_o,
   output reg dack_o,
   output reg [15:0] data_o,
   output reg data_oe_o,
   input wire [15:0] data_i
);

   localparam [1:0] S_IDLE = 2'd0;
   localparam [1:0] S_STROBE = 2'd1;
   localparam [1:0] S_HOLD = 2'd2;
   localparam [1:0] S_RECOVER = 2'd3;
   localparam integer STROBE_NUM = `HCPIO_STROBE_CYC;
   localparam integer RECOVER_NUM = `HCPIO_RECOVER_CYC;
   localparam [3:0] STROBE_CYC = STROBE_NUM[3:0];
   localparam [3:0] RECOVER_CYC = RECOVER_NUM[3:0];

   reg [1:0] state_r;
   reg [3:0] cnt_r;
   reg wr_r;

   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      if (rst_i)
      begin
         state_r <= S_IDLE;
         cnt_r <= 4'h0;
         wr_r <= 1'b0;
         rdata_o <= 16'h0000;
         cs_n_o <= 1'b1;
         a0_o <= 1'b0;
         rd_n_o <= 1'b1;
         wr_n_o <= 1'b1;
         dack_o <= 1'b1;
         data_o <= 16'h0000;
         data_oe_o <= 1'b0;
      end
      else
      begin
         case (state_r)
            S_IDLE:
            begin
               dack_o <= dack_low_i;
               if (start_i)
               begin
                  // DMA words are selected by the grant, plain accesses by chip select
                  cs_n_o <= dma_i;
                  dack_o <= dma_i ? ~dack_low_i : dack_low_i; // [R11] [R17]
                  a0_o <= a0_i; // [R02]
                  wr_r <= wr_i;
                  rd_n_o <= wr_i; // [R03] [R12]
                  wr_n_o <= ~wr_i; // [R03] [R12]
                  data_o <= wdata_i;
                  data_oe_o <= wr_i;
                  cnt_r <= STROBE_CYC;
                  state_r <= S_STROBE;
               end
            end
            S_STROBE:
            begin
               if (cnt_r <= 4'h1)
               begin
                  // Sample at the strobe's last cycle, data is settled by now
                  if (!wr_r)
                     rdata_o <= data_i;
                  rd_n_o <= 1'b1;
                  wr_n_o <= 1'b1;
                  state_r <= S_HOLD;
               end
               else
                  cnt_r <= cnt_r - 4'h1;
            end
            S_HOLD:
            begin
               // Data and select held one cycle past the strobe edge
               cs_n_o <= 1'b1;
               dack_o <= dack_low_i;
               data_oe_o <= 1'b0;
               cnt_r <= RECOVER_CYC;
               state_r <= S_RECOVER;
            end
            S_RECOVER:
            begin
               if (cnt_r <= 4'h1)
               begin
                  done_o <= 1'b1;
                  state_r <= S_IDLE;
               end
               else
                  cnt_r <= cnt_r - 4'h1;
            end
            default:
               state_r <= S_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// *** logic/hcpio_host.v ***
`timescale 1ns/1ps
`default_nettype none
`include "hcpio_regs.vh"

//Contract
// R01 - Device looks like memory, 16-bit data, two locations chosen by port select.
// R02 - Port select 0 is data port, 1 is write-only command port.
// R03 - Read strobe reads data port; write strobe writes command or data.
// R04 - Register index goes in low byte, upper byte driven as zeros.
// R05 - Register access is a command phase then a data phase.
// R06 - Chip identifier at index 27H returns one data word.
// R07 - 32-bit registers take two data phases, low half first.
// R08 - Buffer access: command, then words until half the byte count.
// R09 - One buffer access cycle never mixes reads and writes.
// R10 - Host side masters DMA; device is only a slave channel.
// R11 - Device raises request; host answers with grant and data together.
// R12 - During DMA each word still carries a read or write strobe.
// R13 - Device repeats DMA cycles until an end-of-transfer arrives.
// R14 - Device accepts external end-of-transfer from the host.
// R15 - Counter select bit 2 enables the device's internal end-of-transfer counter.
// R16 - DMA supports single-cycle and burst transfers.
// R17 - Request active high, grant active low here; polarities are configurable.
// R18 - Interrupt line has four modes: level or edge, low or high.
// R19 - Interrupt mode and enable programmed in hardware setup register.
// R20 - Hardware setup bit 0 enables the line; bits 1,2 pick trigger, polarity.
// R21 - With master enable 0 the interrupt line holds its level.
// R22 - Edge modes give one fixed-width pulse per new interrupt.
module hcpio_host
(
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output wire chip_select_n_o,
   output wire port_select_line_o,
   output wire read_strobe_n_o,
   output wire write_strobe_n_o,
   output wire [15:0] data_o,
   output wire data_oe_o,
   input wire [15:0] data_i,
   input wire transfer_request_in_i,
   output wire transfer_grant_low_o,
   output reg end_of_transfer_o,
   input wire interrupt_line_i
);

   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_CMD = 3'd1;
   localparam [2:0] S_DATA = 3'd2;
   localparam [2:0] S_DMA_WAIT = 3'd3;
   localparam [2:0] S_DMA_XFER = 3'd4;

   reg [15:0] buf_mem [0:255];

   reg [2:0] state_r;
   reg [2:0] op_r;
   reg [7:0] idx_r;
   reg [31:0] wdata_r;
   reg [31:0] rdata_r;
   reg [15:0] bcount_r;
   reg [5:0] cfg_r;
   reg [7:0] cpu_ptr_r;
   reg [7:0] eng_ptr_r;
   reg [15:0] words_r;
   reg [15:0] left_r;
   reg done_r;
   reg irq_edge_r;
   reg irq_prev_r;
   reg eot_val_r;
   reg start_r;
   reg a0_r;
   reg wr_r;
   reg dma_r;
   reg [15:0] wword_r;

   wire cyc_done;
   wire [15:0] cyc_rdata;
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i;
   wire wb_rd = wb_req & ~wb_we_i;
   wire [2:0] ctrl_op = wb_dat_i[`HCPIO_CTRL_OP_MSB:`HCPIO_CTRL_OP_LSB];
   wire go = wb_wr & (wb_adr_i == `HCPIO_ADR_CTRL) & wb_dat_i[`HCPIO_CTRL_GO] & wb_sel_i[3];
   wire abort = wb_wr & (wb_adr_i == `HCPIO_ADR_CTRL) & wb_dat_i[`HCPIO_CTRL_ABORT] & wb_sel_i[3];
   wire op_wr = op_r[0];
   wire op_dma = (op_r == `HCPIO_OP_DMARD) | (op_r == `HCPIO_OP_DMAWR);
   wire op_buf = (op_r == `HCPIO_OP_BUFRD) | (op_r == `HCPIO_OP_BUFWR);
   wire op_32 = (op_r == `HCPIO_OP_RD32) | (op_r == `HCPIO_OP_WR32);
   wire transfer_request_out_act = cfg_r[`HCPIO_CFG_TRANSFER_REQUEST_OUT_HI] ? transfer_request_in_i : ~transfer_request_in_i; // [R17]
   wire irq_act = cfg_r[`HCPIO_CFG_IRQ_POL] ? interrupt_line_i : ~interrupt_line_i; // [R18]
   wire irq_rise = irq_act & ~irq_prev_r;
   wire [15:0] half_count = {1'b0, bcount_r[15:1]};
   wire [15:0] buf_wword = buf_mem[eng_ptr_r];
   wire [31:0] status_w = {words_r, 11'h000, transfer_request_out_act, irq_edge_r, irq_act, done_r, (state_r != S_IDLE)};

   hcpio_cycle u_cycle
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(start_r),
      .a0_i(a0_r),
      .wr_i(wr_r),
      .dma_i(dma_r),
      .dack_low_i(cfg_r[`HCPIO_CFG_DACK_LO]),
      .wdata_i(wword_r),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .cs_n_o(chip_select_n_o),
      .a0_o(port_select_line_o),
      .rd_n_o(read_strobe_n_o),
      .wr_n_o(write_strobe_n_o),
      .dack_o(transfer_grant_low_o),
      .data_o(data_o),
      .data_oe_o(data_oe_o),
      .data_i(data_i)
   );

   // Wishbone slave: ack one cycle after the request, dropped the cycle after
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         bcount_r <= 16'h0000;
         cfg_r <= `HCPIO_CFG_RESET;
         cpu_ptr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_rd)
         begin
            case (wb_adr_i)
               `HCPIO_ADR_CTRL: wb_dat_o <= {29'h0000_0000, op_r};
               `HCPIO_ADR_WDATA: wb_dat_o <= wdata_r;
               `HCPIO_ADR_RDATA: wb_dat_o <= rdata_r;
               `HCPIO_ADR_STATUS: wb_dat_o <= status_w;
               `HCPIO_ADR_BCOUNT: wb_dat_o <= {16'h0000, bcount_r};
               `HCPIO_ADR_BUFPTR: wb_dat_o <= {24'h00_0000, cpu_ptr_r};
               `HCPIO_ADR_BUFDATA: wb_dat_o <= {16'h0000, buf_mem[cpu_ptr_r]};
               `HCPIO_ADR_CFG: wb_dat_o <= {26'h000_0000, cfg_r};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
            if (wb_adr_i == `HCPIO_ADR_BUFDATA)
               cpu_ptr_r <= cpu_ptr_r + 8'h01;
         end
         if (wb_wr)
         begin
            case (wb_adr_i)
               `HCPIO_ADR_WDATA:
               begin
                  if (wb_sel_i[0]) wdata_r[7:0] <= wb_dat_i[7:0];
                  if (wb_sel_i[1]) wdata_r[15:8] <= wb_dat_i[15:8];
                  if (wb_sel_i[2]) wdata_r[23:16] <= wb_dat_i[23:16];
                  if (wb_sel_i[3]) wdata_r[31:24] <= wb_dat_i[31:24];
               end
               `HCPIO_ADR_BCOUNT:
                  if (wb_sel_i[1:0] == 2'b11 && state_r == S_IDLE)
                     bcount_r <= wb_dat_i[15:0];
               `HCPIO_ADR_BUFPTR:
                  if (wb_sel_i[0])
                     cpu_ptr_r <= wb_dat_i[7:0];
               `HCPIO_ADR_BUFDATA:
                  cpu_ptr_r <= cpu_ptr_r + 8'h01;
               `HCPIO_ADR_CFG:
                  if (wb_sel_i[0])
                     cfg_r <= wb_dat_i[5:0];
               default:
               begin
               end
            endcase
         end
      end
   end

   // Buffer array has one writer process: software side or read-back words
   always @(posedge clk_i)
   begin
      if (wb_wr && wb_adr_i == `HCPIO_ADR_BUFDATA && wb_sel_i[1:0] == 2'b11)
         buf_mem[cpu_ptr_r] <= wb_dat_i[15:0];
      else if (cyc_done && !op_wr && (op_buf || op_dma) && state_r != S_CMD)
         buf_mem[eng_ptr_r] <= cyc_rdata;
   end

   // Status flags; a hardware set wins over a same-cycle software clear
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_prev_r <= 1'b0;
         irq_edge_r <= 1'b0;
      end
      else
      begin
         irq_prev_r <= irq_act;
         if (cfg_r[`HCPIO_CFG_IRQ_EDGE] && irq_rise)
            irq_edge_r <= 1'b1; // [R18]
         else if (wb_wr && wb_adr_i == `HCPIO_ADR_STATUS && wb_dat_i[`HCPIO_ST_IRQ_EDGE])
            irq_edge_r <= 1'b0;
      end
   end

   // Transfer sequencer
   always @(posedge clk_i)
   begin
      start_r <= 1'b0;
      if (rst_i)
      begin
         state_r <= S_IDLE;
         op_r <= `HCPIO_OP_RD16;
         idx_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
         eng_ptr_r <= 8'h00;
         words_r <= 16'h0000;
         left_r <= 16'h0000;
         done_r <= 1'b0;
         eot_val_r <= 1'b0;
         a0_r <= 1'b0;
         wr_r <= 1'b0;
         dma_r <= 1'b0;
         wword_r <= 16'h0000;
      end
      else
      begin
         if (wb_wr && wb_adr_i == `HCPIO_ADR_STATUS && wb_dat_i[`HCPIO_ST_DONE])
            done_r <= 1'b0;
         case (state_r)
            S_IDLE:
            begin
               if (go)
               begin
                  op_r <= ctrl_op;
                  idx_r <= wb_dat_i[`HCPIO_CTRL_IDX_MSB:`HCPIO_CTRL_IDX_LSB];
                  done_r <= 1'b0;
                  words_r <= 16'h0000;
                  eng_ptr_r <= cpu_ptr_r;
                  if (ctrl_op == `HCPIO_OP_DMARD || ctrl_op == `HCPIO_OP_DMAWR)
                  begin
                     left_r <= half_count; // [R08]
                     state_r <= S_DMA_WAIT; // [R10]
                  end
                  else
                  begin
                     // Index in the low byte, upper byte forced to zero
                     wword_r <= {`HCPIO_CMD_UPPER, wb_dat_i[`HCPIO_CTRL_IDX_MSB:`HCPIO_CTRL_IDX_LSB]}; // [R04]
                     a0_r <= `HCPIO_PORT_CMD; // [R02]
                     wr_r <= 1'b1;
                     dma_r <= 1'b0;
                     start_r <= 1'b1; // [R05]
                     state_r <= S_CMD;
                  end
               end
            end
            S_CMD:
            begin
               if (cyc_done)
               begin
                  if (op_buf)
                     left_r <= half_count; // [R08]
                  else if (op_32)
                     left_r <= 16'h0002; // [R07]
                  else
                     left_r <= 16'h0001; // [R06]
                  state_r <= S_DATA;
               end
            end
            S_DATA:
            begin
               // One direction throughout the cycle, fixed by the latched op
               if (left_r == 16'h0000)
               begin
                  done_r <= 1'b1;
                  state_r <= S_IDLE;
               end
               else if (!start_r)
               begin
                  a0_r <= `HCPIO_PORT_DATA; // [R02]
                  wr_r <= op_wr; // [R09]
                  dma_r <= 1'b0;
                  wword_r <= op_buf ? buf_wword : (words_r[0] ? wdata_r[31:16] : wdata_r[15:0]); // [R07]
                  start_r <= 1'b1;
                  state_r <= S_DMA_XFER;
               end
            end
            S_DMA_WAIT:
            begin
               if (abort || left_r == 16'h0000)
               begin
                  done_r <= 1'b1;
                  state_r <= S_IDLE;
               end
               else if (transfer_request_out_act)
               begin
                  // A word per sampled request; a held request bursts back to back
                  a0_r <= `HCPIO_PORT_DATA;
                  wr_r <= op_wr;
                  dma_r <= 1'b1; // [R11]
                  wword_r <= buf_wword;
                  eot_val_r <= cfg_r[`HCPIO_CFG_EOT_EN] & (left_r == 16'h0001); // [R14]
                  start_r <= 1'b1; // [R16]
                  state_r <= S_DMA_XFER;
               end
            end
            S_DMA_XFER:
            begin
               if (cyc_done)
               begin
                  eot_val_r <= 1'b0;
                  left_r <= left_r - 16'h0001;
                  words_r <= words_r + 16'h0001;
                  if (op_buf || op_dma)
                     eng_ptr_r <= eng_ptr_r + 8'h01;
                  else if (!op_wr)
                  begin
                     if (words_r[0])
                        rdata_r[31:16] <= cyc_rdata; // [R07]
                     else
                        rdata_r <= {16'h0000, cyc_rdata}; // [R06]
                  end
                  // Device ending early via its own counter just drops the request
                  state_r <= dma_r ? S_DMA_WAIT : S_DATA; // [R13] [R15]
               end
            end
            default:
               state_r <= S_IDLE;
         endcase
      end
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
         end_of_transfer_o <= 1'b1;
      else
         end_of_transfer_o <= cfg_r[`HCPIO_CFG_EOT_HI] ? eot_val_r : ~eot_val_r; // [R14]
   end

endmodule
`default_nettype wire

// *** test/hcpio_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module hcpio_chk
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic chip_select_n_o,
   input wire logic port_select_line_o,
   input wire logic read_strobe_n_o,
   input wire logic write_strobe_n_o,
   input wire logic [15:0] data_o,
   input wire logic data_oe_o,
   input wire logic transfer_grant_low_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // A strobe stays low for exactly two cycles, then lifts
   sequence low_two_s(logic s);
      !s ##1 s;
   endsequence
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   reset_idle_a: assert property ($fell(rst_i) |-> chip_select_n_o && read_strobe_n_o && write_strobe_n_o && !data_oe_o)
      else $error("pins not idle after reset");
   strobe_excl_a: assert property (!(!read_strobe_n_o && !write_strobe_n_o))
      else $error("both strobes low");
   cmd_noread_a: assert property (!chip_select_n_o && port_select_line_o |-> read_strobe_n_o)
      else $error("command port read");
   cmd_upper_a: assert property (!chip_select_n_o && port_select_line_o && !write_strobe_n_o |-> data_o[15:8] == 8'h00)
      else $error("command upper byte");
   write_drive_a: assert property (!write_strobe_n_o |-> data_oe_o)
      else $error("write without drive");
   read_float_a: assert property (!read_strobe_n_o |-> !data_oe_o)
      else $error("read while driving");
   write_width_a: assert property ($fell(write_strobe_n_o) |=> low_two_s(write_strobe_n_o))
      else $error("write strobe width");
   read_width_a: assert property ($fell(read_strobe_n_o) |=> low_two_s(read_strobe_n_o))
      else $error("read strobe width");
   dma_nocs_a: assert property (!transfer_grant_low_o |-> chip_select_n_o)
      else $error("select during grant");
   strobe_sel_a: assert property (!read_strobe_n_o || !write_strobe_n_o |-> !chip_select_n_o || !transfer_grant_low_o)
      else $error("strobe unselected");
endmodule
bind hcpio_host hcpio_chk hcpio_chk_inst
(
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .chip_select_n_o, .port_select_line_o,
   .read_strobe_n_o, .write_strobe_n_o, .data_o, .data_oe_o, .transfer_grant_low_o
);
`default_nettype wire

// *** test/hcpio_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hcpio_dev_model
#(
   parameter logic [15:0] CHIP_ID = 16'h5a3c
)
(
   input wire logic clk_i,
   input wire logic cs_n_i,
   input wire logic a0_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o,
   input wire logic transfer_grant_low_i,
   input wire logic eot_n_i,
   input wire logic arm_i,
   output logic transfer_request_out_o,
   input wire logic event_i,
   output logic irq_o
);
   logic [15:0] mem [int];
   logic [7:0] idx = 8'h00;
   logic [15:0] last = 16'h0000;
   logic [15:0] hw, cfg;
   logic [1:0] pc_r = 2'h0;
   logic ev_r = 1'b0;
   logic eot_r = 1'b0;
   int ptr = 0;
   int dn = 0;
   wire logic sel = !cs_n_i && !a0_i;
   function automatic logic [15:0] rv(input int k);
      return mem.exists(k) ? mem[k] : 16'h0000;
   endfunction
   initial
   begin
      irq_o = 1'b1;
      transfer_request_out_o = 1'b0;
   end
   // Released bus shows the inverse of the last word, never a stale copy
   always @*
      if (!rd_n_i && !transfer_grant_low_i)
         data_o = rv(16'h4000 + dn);
      else if (!rd_n_i && sel)
         data_o = idx == 8'h27 ? CHIP_ID : rv(idx[6:0] * 256 + ptr);
      else
         data_o = ~last;
   always @(posedge wr_n_i)
      if (!cs_n_i && a0_i)
      begin
         idx = data_i[7:0];
         ptr = 0;
      end
      else if (sel)
      begin
         if (idx[7])
            mem[idx[6:0] * 256 + ptr] = data_i;
         ptr++;
      end
   always @(posedge rd_n_i)
   begin
      last = data_o;
      if (!transfer_grant_low_i)
         dn++;
      else if (sel)
         ptr++;
   end
   always @(posedge clk_i)
   begin
      hw = rv(16'h2000);
      cfg = rv(16'h2100);
      if (!arm_i)
      begin
         dn = 0;
         eot_r = 1'b0;
      end
      if (!eot_n_i && arm_i)
         eot_r = 1'b1;
      transfer_request_out_o <= arm_i && !eot_r && !(cfg[2] && dn >= rv(16'h2200) / 2);
      ev_r <= event_i;
      if (hw[0])
      begin
         if (event_i && !ev_r && hw[1])
            pc_r <= 2'h2;
         else if (pc_r != 2'h0)
            pc_r <= pc_r - 2'h1;
         irq_o <= (hw[1] ? pc_r != 2'h0 : event_i) ~^ hw[2];
      end
   end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hcpio_regs.vh"
module testbench;
   localparam logic [15:0] CHIP_ID = 16'h5a3c; // Arbitrary value
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic arm = 1'b0;
   logic ev = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rq, st, v, dat;
   logic ack, cs_n, a0, rd_n, wr_n, oe, transfer_request_out, transfer_grant_low, end_of_transfer_in, irq;
   logic [15:0] hd, md;
   logic [15:0] q[$];
   int num_errors = 0;
   int comparisons = 0;
   wire logic [15:0] bus = oe ? hd : md;
   hcpio_host hcpio_host_inst
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .chip_select_n_o(cs_n),
      .port_select_line_o(a0), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .data_o(hd),
      .data_oe_o(oe), .data_i(bus), .transfer_request_in_i(transfer_request_out), .transfer_grant_low_o(transfer_grant_low),
      .end_of_transfer_o(end_of_transfer_in), .interrupt_line_i(irq)
   );
   hcpio_dev_model #(.CHIP_ID(CHIP_ID)) hcpio_dev_model_inst
   (
      .clk_i(clk_i), .cs_n_i(cs_n), .a0_i(a0), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(bus),
      .data_o(md), .transfer_grant_low_i(transfer_grant_low), .eot_n_i(end_of_transfer_in), .arm_i(arm), .transfer_request_out_o(transfer_request_out),
      .event_i(ev), .irq_o(irq)
   );
   initial
      forever #10 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do
      begin
         @(posedge clk_i);
      end
      while (ack !== 1'b1);
      rq = dat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   // Runs one device operation and polls status until it is no longer busy
   task automatic go(input logic [2:0] op, input logic [7:0] ix, input logic [31:0] d);
      wb(1'b1, `HCPIO_ADR_WDATA, d);
      wb(1'b1, `HCPIO_ADR_CTRL, {1'b1, 20'h0_0000, op, ix});
      do
      begin
         wb(1'b0, `HCPIO_ADR_STATUS, 32'h0000_0000);
         // Device counter end only drops the request, so software ends the wait
         if (rq[`HCPIO_ST_BUSY] === 1'b1 && rq[`HCPIO_ST_TRANSFER_REQUEST_OUT] === 1'b0)
            wb(1'b1, `HCPIO_ADR_CTRL, 32'h4000_0000);
      end
      while (rq[`HCPIO_ST_BUSY] !== 1'b0);
      st = rq;
      chk(st[`HCPIO_ST_DONE], 32'h0000_0001);
      wb(1'b1, `HCPIO_ADR_STATUS, 32'h0000_0002);
      wb(1'b0, `HCPIO_ADR_RDATA, 32'h0000_0000);
   endtask
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      v = $urandom(32'h4a0c5b86);
      @(posedge clk_i);
      wb(1'b0, `HCPIO_ADR_CFG, 32'h0000_0000);
      chk(rq, 32'h0000_001c);
      wb(1'b1, 8'h40, 32'hffff_ffff);
      wb(1'b0, 8'h40, 32'h0000_0000);
      chk(rq, 32'h0000_0000);
      go(`HCPIO_OP_RD16, `HCPIO_IDX_CHIP_ID, 32'h0000_0000);
      chk(rq[15:0], CHIP_ID);
      v = $urandom;
      go(`HCPIO_OP_WR16, `HCPIO_IDX_DMA_SETUP_WR, v);
      go(`HCPIO_OP_RD16, `HCPIO_IDX_DMA_SETUP_RD, 32'h0000_0000);
      chk(rq[15:0], v[15:0]);
      v = $urandom;
      go(`HCPIO_OP_WR32, 8'h81, v);
      go(`HCPIO_OP_RD32, 8'h01, 32'h0000_0000);
      chk(rq, v);
      go(`HCPIO_OP_RD16, 8'h01, 32'h0000_0000);
      chk(rq[15:0], v[15:0]);
      wb(1'b1, `HCPIO_ADR_BCOUNT, 32'h0000_0008);
      wb(1'b1, `HCPIO_ADR_BUFPTR, 32'h0000_0000);
      repeat (4)
      begin
         v = $urandom;
         q.push_back(v[15:0]);
         wb(1'b1, `HCPIO_ADR_BUFDATA, v);
      end
      wb(1'b1, `HCPIO_ADR_BUFPTR, 32'h0000_0000);
      go(`HCPIO_OP_BUFWR, 8'hc0, 32'h0000_0000);
      chk(st[31:16], 32'h0000_0004);
      wb(1'b1, `HCPIO_ADR_BUFPTR, 32'h0000_0000);
      repeat (4) wb(1'b1, `HCPIO_ADR_BUFDATA, 32'h0000_0000);
      wb(1'b1, `HCPIO_ADR_BUFPTR, 32'h0000_0000);
      go(`HCPIO_OP_BUFRD, 8'h40, 32'h0000_0000);
      wb(1'b1, `HCPIO_ADR_BUFPTR, 32'h0000_0000);
      foreach (q[i])
      begin
         wb(1'b0, `HCPIO_ADR_BUFDATA, 32'h0000_0000);
         chk(rq[15:0], q[i]);
      end
      // Counter end stops after three words, pin end after two
      go(`HCPIO_OP_WR16, `HCPIO_IDX_BYTE_COUNT_WR, 32'h0000_0006);
      for (int i = 0; i < 2; i++)
      begin
         go(`HCPIO_OP_WR16, `HCPIO_IDX_DMA_SETUP_WR, i ? 32'h0000_0000 : 32'h0000_0004);
         wb(1'b1, `HCPIO_ADR_BCOUNT, i ? 32'h0000_0004 : 32'h0000_0008);
         wb(1'b1, `HCPIO_ADR_BUFPTR, 32'h0000_0010);
         arm <= 1'b1;
         go(`HCPIO_OP_DMARD, 8'h00, 32'h0000_0000);
         chk(st[31:16], 3 - i);
         chk(transfer_request_out, 32'h0000_0000);
         arm <= 1'b0;
         wb(1'b1, `HCPIO_ADR_BUFPTR, 32'h0000_0010);
         for (int k = 0; k < 3 - i; k++)
         begin
            wb(1'b0, `HCPIO_ADR_BUFDATA, 32'h0000_0000);
            chk(rq[15:0], q[k]);
         end
      end
      for (int m = 0; m < 4; m++)
      begin
         go(`HCPIO_OP_WR16, `HCPIO_IDX_HW_SETUP_WR, {29'h0, m[0], m[1], 1'b1});
         wb(1'b1, `HCPIO_ADR_CFG, {27'h0, 3'b111, m[1], m[0]});
         wb(1'b1, `HCPIO_ADR_STATUS, 32'h0000_0008);
         ev <= 1'b1;
         repeat (4) @(posedge clk_i);
         wb(1'b0, `HCPIO_ADR_STATUS, 32'h0000_0000);
         chk(rq[m[1] ? 3 : 2], 32'h0000_0001);
         ev <= 1'b0;
         repeat (4) @(posedge clk_i);
         wb(1'b0, `HCPIO_ADR_STATUS, 32'h0000_0000);
         chk(rq[2], 32'h0000_0000);
      end
      complete_run();
   end
   initial
   begin
      repeat (40000) @(posedge clk_i);
      num_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
